// file: core/chfcr_regs.sv
// Command, interface ownership and FIFO configuration registers
`include "chfcr_params.svh"

module chfcr_regs (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         srst,
   // Host register access
   input  wire chfcr_pkg::chfcr_req_type     req,
   output logic [7:0]                        rd_data,
   output logic                              rd_valid,
   // Command control
   output logic                              power_down,
   output logic                              radio_power_down,
   output logic [`CHFCR_CMD_CODE_W-1:0]      cmd_code,
   output logic                              cmd_start,
   // Interface ownership
   output logic                              bus_owner_host_side,
   output logic                              bus_owner_secure_module,
   output chfcr_pkg::chfcr_link_type         secure_module_link_select,
   // FIFO status
   output logic                              fifo_clear,
   output logic [`CHFCR_FILL_W-1:0]          fill_count,
   output logic                              fifo_near_full_flag,
   output logic                              fifo_near_empty_flag
);
   import chfcr_pkg::*;

   // ==========================================================
   // Decoding helpers
   function automatic logic [`CHFCR_FILL_W-1:0] capacity(
      input logic depth);
      capacity = depth ? `CHFCR_CAP_SMALL : `CHFCR_CAP_LARGE;
   endfunction : capacity

   // Extension bit ignored in the 255-byte mode
   function automatic logic [`CHFCR_TH_W-1:0] threshold(
      input logic       depth,
      input logic       msb,
      input logic [7:0] low);
      threshold = {msb & ~depth, low};
   endfunction : threshold

   function automatic logic near_full(
      input logic [`CHFCR_FILL_W-1:0] fill,
      input logic                     depth,
      input logic [`CHFCR_TH_W-1:0]   th);
      near_full = (capacity(depth) - fill) <= {1'b0, th};
   endfunction : near_full

   function automatic logic near_empty(
      input logic [`CHFCR_FILL_W-1:0] fill,
      input logic [`CHFCR_TH_W-1:0]   th);
      near_empty = fill <= {1'b0, th};
   endfunction : near_empty

   // ==========================================================
   // State
   chfcr_state_type state;
   chfcr_state_type next_state;

   logic wr_cmd;
   logic wr_own;
   logic wr_setup;
   logic wr_th;
   logic wr_port;
   logic rd_port;

   assign wr_cmd   = req.wr && req.addr == `CHFCR_OFS_COMMAND;
   assign wr_own   = req.wr && req.addr == `CHFCR_OFS_OWNERSHIP;
   assign wr_setup = req.wr && req.addr == `CHFCR_OFS_FIFO_SETUP;
   assign wr_th    = req.wr && req.addr == `CHFCR_OFS_THRESHOLD;
   assign wr_port  = req.wr && req.addr == `CHFCR_OFS_FIFO_PORT;
   assign rd_port  = req.rd && !req.wr
                     && req.addr == `CHFCR_OFS_FIFO_PORT;

   // ==========================================================
   // Next state
   always_comb begin
      logic [`CHFCR_TH_W-1:0] th;
      th = '0;
      next_state = state;
      next_state.rd_valid = 1'b0;
      next_state.cmd_start = 1'b0;
      next_state.fifo_clear = 1'b0;

      if (wr_cmd) begin
         next_state.power_down = req.wdata[`CHFCR_CMD_STANDBY];
         next_state.radio_power_down =
            req.wdata[`CHFCR_CMD_RADIO_OFF];
         next_state.cmd_code =
            req.wdata[`CHFCR_CMD_CODE_HI:0];
         next_state.cmd_start = 1'b1;
      end

      // Unlock lasts for exactly one following write
      if (req.wr) begin
         next_state.ownership_write_unlock = 1'b0;
      end
      if (wr_own) begin
         next_state.secure_module_link_select = chfcr_link_type'(
            req.wdata[`CHFCR_OWN_LINK_HI:`CHFCR_OWN_LINK_LO]);
         next_state.ownership_write_unlock =
            req.wdata[`CHFCR_OWN_UNLOCK];
         // Both set at once leaves both owner bits unchanged, so the two are never set together
         if (state.ownership_write_unlock
             && !(req.wdata[`CHFCR_OWN_HOST]
                  && req.wdata[`CHFCR_OWN_SAM])) begin
            next_state.bus_owner_host_side =
               req.wdata[`CHFCR_OWN_HOST];
            next_state.bus_owner_secure_module =
               req.wdata[`CHFCR_OWN_SAM];
         end
      end

      if (wr_setup) begin
         next_state.fifo_depth_select = req.wdata[`CHFCR_FS_DEPTH];
         next_state.threshold_msb = req.wdata[`CHFCR_FS_TH_MSB];
         next_state.fifo_clear = req.wdata[`CHFCR_FS_CLEAR];
      end
      if (wr_th) begin
         next_state.threshold_low_byte = req.wdata;
      end

      // Count saturates at the capacity and at zero
      if (wr_setup && req.wdata[`CHFCR_FS_CLEAR]) begin
         next_state.fill_count = `CHFCR_RST_FILL;
      end else if (wr_port
                   && state.fill_count < capacity(state.fifo_depth_select))
      begin
         next_state.fill_count = state.fill_count + 1'b1;
      end else if (rd_port && state.fill_count != `CHFCR_RST_FILL) begin
         next_state.fill_count = state.fill_count - 1'b1;
      end

      th = threshold(next_state.fifo_depth_select,
                     next_state.threshold_msb,
                     next_state.threshold_low_byte);
      next_state.fifo_near_full_flag = near_full(
         next_state.fill_count, next_state.fifo_depth_select, th);
      next_state.fifo_near_empty_flag =
         near_empty(next_state.fill_count, th);

      // Reads, ignored while a write is requested, return the value held before this edge
      if (req.rd && !req.wr) begin
         next_state.rd_valid = 1'b1;
         unique case (req.addr)
            `CHFCR_OFS_COMMAND:
               next_state.rd_data = {state.power_down,
                  state.radio_power_down, 1'b0, state.cmd_code};
            `CHFCR_OFS_OWNERSHIP:
               next_state.rd_data = {state.ownership_write_unlock,
                  state.bus_owner_host_side,
                  state.bus_owner_secure_module, 1'b0,
                  state.secure_module_link_select, 2'h0};
            `CHFCR_OFS_FIFO_SETUP:
               next_state.rd_data = {state.fifo_depth_select,
                  state.fifo_near_full_flag, state.fifo_near_empty_flag,
                  2'h0, state.threshold_msb,
                  state.fill_count[`CHFCR_FILL_W-1:8]};
            `CHFCR_OFS_THRESHOLD:
               next_state.rd_data = state.threshold_low_byte;
            `CHFCR_OFS_FILL_LOW:
               next_state.rd_data = state.fill_count[7:0];
            default:
               next_state.rd_data = `CHFCR_RST_BYTE;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
         // Empty FIFO against a zero threshold is already near-empty
         state.fifo_near_empty_flag <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Outputs
   assign rd_data                   = state.rd_data;
   assign rd_valid                  = state.rd_valid;
   assign power_down                = state.power_down;
   assign radio_power_down          = state.radio_power_down;
   assign cmd_code                  = state.cmd_code;
   assign cmd_start                 = state.cmd_start;
   assign bus_owner_host_side       = state.bus_owner_host_side;
   assign bus_owner_secure_module   = state.bus_owner_secure_module;
   assign secure_module_link_select = state.secure_module_link_select;
   assign fifo_clear                = state.fifo_clear;
   assign fill_count                = state.fill_count;
   assign fifo_near_full_flag       = state.fifo_near_full_flag;
   assign fifo_near_empty_flag      = state.fifo_near_empty_flag;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_standby;
      wr_cmd |=> power_down == $past(req.wdata[`CHFCR_CMD_STANDBY]);
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby bit not applied");

   property p_radio;
      wr_cmd |=> radio_power_down
                 == $past(req.wdata[`CHFCR_CMD_RADIO_OFF]) ##1
                 (radio_power_down || !$past(radio_power_down)
                  || wr_cmd || $past(wr_cmd));
   endproperty
   a_radio: assert property (p_radio)
      else $error("radio power-down bit not applied");

   property p_cmd_code;
      wr_cmd |=> cmd_start && cmd_code == $past(req.wdata[4:0]);
   endproperty
   a_cmd_code: assert property (p_cmd_code)
      else $error("command code not taken");

   property p_unlock_clear;
      req.wr && !(wr_own && req.wdata[`CHFCR_OWN_UNLOCK])
      |=> !state.ownership_write_unlock;
   endproperty
   a_unlock_clear: assert property (p_unlock_clear)
      else $error("unlock survived a write");

   property p_take_host;
      wr_own && state.ownership_write_unlock
      && req.wdata[`CHFCR_OWN_HOST] && !req.wdata[`CHFCR_OWN_SAM]
      |=> bus_owner_host_side && !bus_owner_secure_module;
   endproperty
   a_take_host: assert property (p_take_host)
      else $error("host ownership refused after unlock");

   property p_take_sam;
      wr_own && state.ownership_write_unlock
      && req.wdata[`CHFCR_OWN_SAM] && !req.wdata[`CHFCR_OWN_HOST]
      |=> bus_owner_secure_module && !bus_owner_host_side;
   endproperty
   a_take_sam: assert property (p_take_sam)
      else $error("module ownership refused after unlock");

   property p_one_owner;
      !(bus_owner_host_side && bus_owner_secure_module);
   endproperty
   a_one_owner: assert property (p_one_owner)
      else $error("both bus owners set");

   property p_link;
      wr_own |=> secure_module_link_select == $past(req.wdata[3:2]);
   endproperty
   a_link: assert property (p_link)
      else $error("link select not applied");

   property p_flags;
      fifo_near_full_flag == near_full(fill_count,
         state.fifo_depth_select,
         threshold(state.fifo_depth_select, state.threshold_msb,
                   state.threshold_low_byte))
      && fifo_near_empty_flag == near_empty(fill_count,
         threshold(state.fifo_depth_select, state.threshold_msb,
                   state.threshold_low_byte));
   endproperty
   a_flags: assert property (p_flags)
      else $error("alert flags disagree with fill and threshold");

   property p_clear;
      wr_setup && req.wdata[`CHFCR_FS_CLEAR]
      |=> fill_count == `CHFCR_RST_FILL && fifo_clear;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not empty the count");

   property p_count;
      wr_port && fill_count < capacity(state.fifo_depth_select)
      |=> fill_count == $past(fill_count) + 1'b1;
   endproperty
   a_count: assert property (p_count)
      else $error("port write did not count");

   property p_fill_read;
      req.rd && !req.wr && req.addr == `CHFCR_OFS_FILL_LOW
      |=> rd_valid && rd_data == $past(fill_count[7:0]);
   endproperty
   a_fill_read: assert property (p_fill_read)
      else $error("fill low byte read wrong");

   property p_locked;
      wr_own && !state.ownership_write_unlock
      |=> $stable(bus_owner_host_side)
          && $stable(bus_owner_secure_module);
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked ownership changed");

   property p_count_down;
      rd_port && fill_count != `CHFCR_RST_FILL
      |=> fill_count == $past(fill_count) - 1'b1;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("port read did not count down");

   // Capacity reached: further port writes are dropped
   property p_saturate;
      wr_port && fill_count >= capacity(state.fifo_depth_select)
      |=> $stable(fill_count);
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("count passed the selected capacity");

   property p_setup_read;
      req.rd && !req.wr && req.addr == `CHFCR_OFS_FIFO_SETUP
      |=> rd_valid && !rd_data[`CHFCR_FS_CLEAR]
          && rd_data[1:0] == $past(fill_count[9:8]);
   endproperty
   a_setup_read: assert property (p_setup_read)
      else $error("fifo setup read back wrong");

   property p_threshold;
      wr_th |=> state.threshold_low_byte == $past(req.wdata);
   endproperty
   a_threshold: assert property (p_threshold)
      else $error("threshold byte not stored");

endmodule : chfcr_regs

// file: core/chfcr_params.svh
// Offsets, field positions, reset values and sizes of the control group
`ifndef CHFCR_PARAMS_SVH
`define CHFCR_PARAMS_SVH

// ==========================================================
// Register offsets
`define CHFCR_ADDR_W          7
`define CHFCR_OFS_COMMAND     7'h00
`define CHFCR_OFS_OWNERSHIP   7'h01
`define CHFCR_OFS_FIFO_SETUP  7'h02
`define CHFCR_OFS_THRESHOLD   7'h03
`define CHFCR_OFS_FILL_LOW    7'h04
`define CHFCR_OFS_FIFO_PORT   7'h05

// ==========================================================
// Command register fields
`define CHFCR_CMD_STANDBY     7
`define CHFCR_CMD_RADIO_OFF   6
`define CHFCR_CMD_CODE_HI     4
`define CHFCR_CMD_CODE_W      5

// ==========================================================
// Interface ownership fields
`define CHFCR_OWN_UNLOCK      7
`define CHFCR_OWN_HOST        6
`define CHFCR_OWN_SAM         5
`define CHFCR_OWN_LINK_HI     3
`define CHFCR_OWN_LINK_LO     2

// ==========================================================
// FIFO setup fields
`define CHFCR_FS_DEPTH        7
`define CHFCR_FS_NEAR_FULL    6
`define CHFCR_FS_NEAR_EMPTY   5
`define CHFCR_FS_CLEAR        4
`define CHFCR_FS_TH_MSB       2

// ==========================================================
// FIFO sizes and reset values
`define CHFCR_FILL_W          10
`define CHFCR_TH_W            9
`define CHFCR_CAP_SMALL       10'h0FF
`define CHFCR_CAP_LARGE       10'h200
`define CHFCR_RST_BYTE        8'h00
`define CHFCR_RST_FILL        10'h000

`endif

// file: core/chfcr_pkg.sv
// Types shared by the control register group
`include "chfcr_params.svh"

package chfcr_pkg;

   // Secondary link selection codes
   typedef enum logic [1:0] {
      CHFCR_LINK_OFF  = 2'h0,
      CHFCR_LINK_SPI  = 2'h1,
      CHFCR_LINK_I2CL = 2'h2,
      CHFCR_LINK_I2C  = 2'h3
   } chfcr_link_type;

   // Host register access, one request per cycle
   typedef struct packed {
      logic                      wr;
      logic                      rd;
      logic [`CHFCR_ADDR_W-1:0]  addr;
      logic [7:0]                wdata;
   } chfcr_req_type;

   // Complete state of the block
   typedef struct packed {
      logic [7:0]                rd_data;
      logic                      rd_valid;
      logic                      power_down;
      logic                      radio_power_down;
      logic [`CHFCR_CMD_CODE_W-1:0] cmd_code;
      logic                      cmd_start;
      logic                      ownership_write_unlock;
      logic                      bus_owner_host_side;
      logic                      bus_owner_secure_module;
      chfcr_link_type            secure_module_link_select;
      logic                      fifo_depth_select;
      logic                      threshold_msb;
      logic [7:0]                threshold_low_byte;
      logic [`CHFCR_FILL_W-1:0]  fill_count;
      logic                      fifo_near_full_flag;
      logic                      fifo_near_empty_flag;
      logic                      fifo_clear;
   } chfcr_state_type;

endpackage : chfcr_pkg

// file: sim/chfcr_host.sv
// Host side model that issues register accesses to the control group
`include "chfcr_params.svh"

module chfcr_host (
   // Clock
   input  wire logic                     core_clk,
   // Answer from the block
   input  wire logic [7:0]               rd_data,
   input  wire logic                     rd_valid,
   // Request to the block
   output chfcr_pkg::chfcr_req_type      req
);
   timeunit 1ns;
   timeprecision 1ps;
   import chfcr_pkg::*;

   initial req = '0;

   // ==========================================================
   // Bus cycles, launched and released on falling edges
   task automatic wr(input logic [`CHFCR_ADDR_W-1:0] a,
                     input logic [7:0] d);
      @(negedge core_clk);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge core_clk);
      req.wr    = 1'b0;
      // Released data scrambled so a stale value cannot pass
      req.wdata = ~d;
   endtask : wr

   // Answer is fixed at one edge, so no open wait is needed
   task automatic rd(input logic [`CHFCR_ADDR_W-1:0] a,
                     output logic [7:0] d,
                     output logic ok);
      @(negedge core_clk);
      req.rd   = 1'b1;
      req.addr = a;
      @(negedge core_clk);
      req.rd   = 1'b0;
      ok       = rd_valid;
      d        = rd_data;
   endtask : rd

endmodule : chfcr_host

// file: sim/tb_chfcr_regs.sv
// Self-checking bench for the command, ownership and FIFO registers
`include "chfcr_params.svh"

module tb_chfcr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import chfcr_pkg::*;

   // ==========================================================
   // Signals
   logic                           core_clk;
   logic                           srst;
   chfcr_req_type                  req;
   logic [7:0]                     rd_data;
   logic                           rd_valid;
   logic                           power_down;
   logic                           radio_power_down;
   logic [`CHFCR_CMD_CODE_W-1:0]   cmd_code;
   logic                           cmd_start;
   logic                           bus_owner_host_side;
   logic                           bus_owner_secure_module;
   chfcr_link_type                 secure_module_link_select;
   logic                           fifo_clear;
   logic [`CHFCR_FILL_W-1:0]       fill_count;
   logic                           fifo_near_full_flag;
   logic                           fifo_near_empty_flag;
   int                             fails;
   int                             n_compared;
   int                             seed;
   int                             exp_fill;
   int                             cap;
   int                             i;
   logic [7:0]                     v;
   logic [7:0]                     th_low;
   logic                           th_msb;
   logic                           depth;

   chfcr_regs uut (
      .core_clk(core_clk), .srst(srst), .req(req),
      .rd_data(rd_data), .rd_valid(rd_valid),
      .power_down(power_down), .radio_power_down(radio_power_down),
      .cmd_code(cmd_code), .cmd_start(cmd_start),
      .bus_owner_host_side(bus_owner_host_side),
      .bus_owner_secure_module(bus_owner_secure_module),
      .secure_module_link_select(secure_module_link_select),
      .fifo_clear(fifo_clear), .fill_count(fill_count),
      .fifo_near_full_flag(fifo_near_full_flag),
      .fifo_near_empty_flag(fifo_near_empty_flag)
   );

   chfcr_host host (
      .core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
      .req(req)
   );

   always #20 core_clk = ~core_clk;

   // ==========================================================
   // Comparison and reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      logic       ok;
      host.rd(a, got, ok);
      check(ok, 1'b1);
      check(got, exp);
   endtask : rchk

   task automatic owners(input logic [1:0] e);
      check({bus_owner_host_side, bus_owner_secure_module}, e);
   endtask : owners

   // ==========================================================
   // FIFO expectation
   function automatic logic [7:0] exp_setup();
      logic [9:0] th;
      logic       nf;
      logic       ne;
      th = depth ? {2'b00, th_low} : {1'b0, th_msb, th_low};
      nf = (cap - exp_fill) <= th;
      ne = exp_fill <= th;
      return {depth, nf, ne, 2'b00, th_msb, exp_fill[9:8]};
   endfunction : exp_setup

   task automatic fchk();
      v = exp_setup();
      rchk(`CHFCR_OFS_FIFO_SETUP, v);
      check({fifo_near_full_flag, fifo_near_empty_flag}, v[6:5]);
      rchk(`CHFCR_OFS_FILL_LOW, exp_fill[7:0]);
      check(fill_count, exp_fill[9:0]);
   endtask : fchk

   task automatic port_io(input bit rd, input int n);
      logic [7:0] got;
      logic       ok;
      repeat (n) begin
         if (rd) begin
            host.rd(`CHFCR_OFS_FIFO_PORT, got, ok);
            if (exp_fill > 0) exp_fill--;
         end else begin
            host.wr(`CHFCR_OFS_FIFO_PORT, 8'($random(seed)));
            if (exp_fill < cap) exp_fill++;
         end
      end
   endtask : port_io

   task automatic set_setup(input logic clr);
      host.wr(`CHFCR_OFS_FIFO_SETUP, {depth, 2'b00, clr, 1'b0, th_msb, 2'b00});
   endtask : set_setup

   // ==========================================================
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      seed = 58;
      fails = 0;
      n_compared = 0;
      exp_fill = 0;
      cap = 512;
      depth = 1'b0;
      th_msb = 1'b0;
      th_low = 8'h00;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) srst = 1'b0;
      // Reset state
      check({power_down, radio_power_down, cmd_code}, 0);
      check(owners_dummy(), 0);
      check({fifo_near_full_flag, fifo_near_empty_flag}, 2'b01);
      rchk(`CHFCR_OFS_COMMAND, 8'h00);
      rchk(`CHFCR_OFS_OWNERSHIP, 8'h00);
      rchk(`CHFCR_OFS_THRESHOLD, 8'h00);
      fchk();
      rchk(7'h10, 8'h00);
      // Command codes, all ones and all zeros first
      for (i = 0; i < 14; i++) begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         host.wr(`CHFCR_OFS_COMMAND, v);
         check({power_down, radio_power_down}, v[7:6]);
         check({cmd_start, cmd_code}, {1'b1, v[4:0]});
         rchk(`CHFCR_OFS_COMMAND, v & 8'hDF);
      end
      // Ownership locking
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h40);
      owners(2'b00);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h20);
      owners(2'b00);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h80);
      rchk(`CHFCR_OFS_OWNERSHIP, 8'h80);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h40);
      owners(2'b10);
      rchk(`CHFCR_OFS_OWNERSHIP, 8'h40);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h80);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h60);
      owners(2'b10);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h80);
      host.wr(`CHFCR_OFS_THRESHOLD, 8'h00);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h20);
      owners(2'b10);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h80);
      host.wr(`CHFCR_OFS_OWNERSHIP, 8'h20);
      owners(2'b01);
      // Every link code, reserved bits written as ones
      for (i = 0; i < 4; i++) begin
         host.wr(`CHFCR_OFS_OWNERSHIP, 8'(i << 2) | 8'h13);
         check(secure_module_link_select, i);
         rchk(`CHFCR_OFS_OWNERSHIP, 8'h20 | 8'(i << 2));
      end
      // Large FIFO mode, fill to past capacity
      th_low = 8'($random(seed));
      th_msb = 1'b1;
      host.wr(`CHFCR_OFS_THRESHOLD, th_low);
      rchk(`CHFCR_OFS_THRESHOLD, th_low);
      set_setup(1'b0);
      fchk();
      while (exp_fill < cap) begin
         port_io(1'b0, 1 + {$random(seed)} % 97);
         fchk();
      end
      port_io(1'b0, 1);
      fchk();
      // Clear empties and reads back zero
      set_setup(1'b1);
      check(fifo_clear, 1'b1);
      exp_fill = 0;
      fchk();
      // Small mode, changed only once empty
      depth = 1'b1;
      cap = 255;
      set_setup(1'b0);
      fchk();
      port_io(1'b0, int'(th_low));
      fchk();
      port_io(1'b0, 1);
      fchk();
      while (exp_fill < cap) begin
         port_io(1'b0, 1 + {$random(seed)} % 61);
         fchk();
      end
      port_io(1'b0, 1);
      fchk();
      while (exp_fill > 0) begin
         port_io(1'b1, 1 + {$random(seed)} % 61);
         fchk();
      end
      final_report();
   end

   function automatic logic [14:0] owners_dummy();
      return {bus_owner_host_side, bus_owner_secure_module,
              secure_module_link_select, fill_count, fifo_clear};
   endfunction : owners_dummy

endmodule : tb_chfcr_regs
